// file: shared/tcmp_consts.vh
`ifndef TCMP_CONSTS_VH
`define TCMP_CONSTS_VH

// register byte offsets
`define TCMP_OFS_FLAGS   8'h00
`define TCMP_OFS_TCR     8'h04
`define TCMP_OFS_TC      8'h08
`define TCMP_OFS_PR      8'h0C
`define TCMP_OFS_PC      8'h10
`define TCMP_OFS_MCR     8'h14
`define TCMP_OFS_MR0     8'h18
`define TCMP_OFS_MR1     8'h1C
`define TCMP_OFS_MR2     8'h20
`define TCMP_OFS_MR3     8'h24
`define TCMP_OFS_CCR     8'h28
`define TCMP_OFS_CR      8'h2C
`define TCMP_OFS_EMR     8'h3C
`define TCMP_OFS_CTCR    8'h70
`define TCMP_OFS_PWM     8'h74
`define TCMP_OFS_MASK    8'h78

// widths
`define TCMP_CW          16
`define TCMP_NMATCH      4
`define TCMP_NFLAG       5

// flag layout: bits 3:0 match 3:0, bit 4 capture
`define TCMP_FLAG_CAP    4

// timer control
`define TCMP_TCR_EN      0
`define TCMP_TCR_RST     1

// match control: three bits per match register
`define TCMP_MCR_INT     0
`define TCMP_MCR_RST     1
`define TCMP_MCR_STOP    2
`define TCMP_MCR_STRIDE  3

// capture control
`define TCMP_CCR_RISE    0
`define TCMP_CCR_FALL    1
`define TCMP_CCR_INT     2

// external match control: state in 3:0, two action bits per match from 4
`define TCMP_EMR_CTL_LSB 4
`define TCMP_EMA_NONE    2'b00
`define TCMP_EMA_LOW     2'b01
`define TCMP_EMA_HIGH    2'b10
`define TCMP_EMA_TOGGLE  2'b11

// count control modes and input select
`define TCMP_CM_TIMER    2'b00
`define TCMP_CM_RISE     2'b01
`define TCMP_CM_FALL     2'b10
`define TCMP_CM_BOTH     2'b11
`define TCMP_CIS_CAP     2'b00

// reset values
`define TCMP_RST_ZERO16  16'h0000
`define TCMP_RST_MASK    5'h1F
`define TCMP_PC_STEP     16'h0001

`endif

// file: rtl/tcmp_cap_sync.v
`timescale 1ns/100ps
// two-stage synchroniser; only the second stage feeds edge detection
module tcmp_cap_sync (
   // clock and reset
   input  wire clk_i,
   input  wire rst_i,
   // raw pin
   input  wire pin_i,
   // edge pulses
   output reg  rise_o,
   output reg  fall_o
);
   reg meta_r;
   reg sync_r;
   reg last_r;

   always @(posedge clk_i) begin
      if (rst_i) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         last_r <= 1'b0;
         rise_o <= 1'b0;
         fall_o <= 1'b0;
      end else begin
         meta_r <= pin_i;
         sync_r <= meta_r;
         last_r <= sync_r;
         rise_o <= sync_r & ~last_r;
         fall_o <= ~sync_r & last_r;
      end
   end
endmodule

// file: rtl/tcmp_timer.v
// The implementer's own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/100ps
`include "tcmp_consts.vh"

// Overview of operation
// - 16-bit count advanced through a 16-bit prescaler dividing the count rate.
// - timer mode counts clock cycles; counter mode counts an external clock.
// - capture input can be chosen as count source instead of the clock.
// - selected capture edge copies count into capture register, optional interrupt.
// - four 16-bit match values compared with count, equality gives match event.
// - a match can let counting continue, optionally flagging an interrupt.
// - a match can stop the counter, optionally flagging an interrupt.
// - a match can reset the counter, optionally flagging an interrupt.
// - match outputs (three or two) go low, high, toggle or hold on match.
// - match output action chosen by external match control and PWM select.
// - match registers usable for PWM; up to three single-edge PWM outputs.
// - both instances identical apart from match pin count (three or two).
// - count advances every prescale limit plus one events; prescale count clears.
// - five pending flags readable; writing ones clears the selected flags.
// - software picks capture edges and whether capture raises an interrupt.
// - software picks timer or counter mode, counted input and edges.
module tcmp_timer #(
   parameter MATCH_PINS = 3
) (
   // clock and reset
   input  wire        clk_i,
   input  wire        rst_i,
   // wishbone slave
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [7:0]  adr_i,
   input  wire [3:0]  sel_i,
   input  wire [31:0] dat_i,
   output reg  [31:0] dat_o,
   output reg         ack_o,
   // capture pin and match pins
   input  wire        capture_input_i,
   output reg  [2:0]  match_outputs_o,
   // interrupt
   output reg         irq_o
);
   // byte-lane merge of the low two lanes
   function [15:0] wb_merge16;
      input [15:0] old;
      input [15:0] dat;
      input [1:0]  sel;
      begin
         wb_merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
      end
   endfunction

   reg  [4:0]  flags_r, flags_nxt;
   reg  [1:0]  tcr_r, tcr_nxt;
   reg  [15:0] tc_r, tc_nxt;
   reg  [15:0] pr_r, pr_nxt;
   reg  [15:0] pc_r, pc_nxt;
   reg  [11:0] mcr_r, mcr_nxt;
   reg  [15:0] mr_r [0:3];
   reg  [15:0] mr_nxt [0:3];
   reg  [2:0]  ccr_r, ccr_nxt;
   reg  [15:0] cr_r, cr_nxt;
   reg  [11:0] emr_r, emr_nxt;
   reg  [3:0]  ctcr_r, ctcr_nxt;
   reg  [3:0]  pwm_r, pwm_nxt;
   reg  [4:0]  mask_r, mask_nxt;
   reg  [31:0] rd_nxt;
   reg  [15:0] tmp16;
   reg  [3:0]  hit;
   reg  [3:0]  hit_rst;
   reg  [3:0]  hit_stop;
   reg  [4:0]  flag_set;
   reg  [1:0]  act;
   reg         cnt_evt;
   reg         run;
   reg         wrap;
   reg         cap_evt;
   reg         wr;
   reg         pin_ok;
   integer     i;

   wire        cap_rise;
   wire        cap_fall;
   wire [2:0]  pin_mask = (MATCH_PINS >= 3) ? 3'b111 : 3'b011;

   tcmp_cap_sync u_sync (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .pin_i  (capture_input_i),
      .rise_o (cap_rise),
      .fall_o (cap_fall)
   );

   always @* begin
      // counting source
      pin_ok  = (ctcr_r[3:2] == `TCMP_CIS_CAP);
      case (ctcr_r[1:0])
         `TCMP_CM_TIMER: cnt_evt = 1'b1;
         `TCMP_CM_RISE:  cnt_evt = pin_ok & cap_rise;
         `TCMP_CM_FALL:  cnt_evt = pin_ok & cap_fall;
         default:        cnt_evt = pin_ok & (cap_rise | cap_fall);
      endcase
      run  = tcr_r[`TCMP_TCR_EN] & ~tcr_r[`TCMP_TCR_RST];
      wrap = run & cnt_evt & (pc_r == pr_r);

      // match detection, evaluated as the count leaves the match value
      for (i = 0; i < `TCMP_NMATCH; i = i + 1) begin
         hit[i]      = wrap & (tc_r == mr_r[i]);
         hit_rst[i]  = hit[i] & mcr_r[i*`TCMP_MCR_STRIDE + `TCMP_MCR_RST];
         hit_stop[i] = hit[i] & mcr_r[i*`TCMP_MCR_STRIDE + `TCMP_MCR_STOP];
         flag_set[i] = hit[i] & mcr_r[i*`TCMP_MCR_STRIDE + `TCMP_MCR_INT];
      end

      // capture on selected edge
      cap_evt = (ccr_r[`TCMP_CCR_RISE] & cap_rise) |
                (ccr_r[`TCMP_CCR_FALL] & cap_fall);
      flag_set[`TCMP_FLAG_CAP] = cap_evt & ccr_r[`TCMP_CCR_INT];

      // defaults
      flags_nxt = flags_r;
      tcr_nxt   = tcr_r;
      tc_nxt    = tc_r;
      pr_nxt    = pr_r;
      pc_nxt    = pc_r;
      mcr_nxt   = mcr_r;
      ccr_nxt   = ccr_r;
      cr_nxt    = cr_r;
      emr_nxt   = emr_r;
      ctcr_nxt  = ctcr_r;
      pwm_nxt   = pwm_r;
      mask_nxt  = mask_r;
      tmp16     = `TCMP_RST_ZERO16;
      for (i = 0; i < `TCMP_NMATCH; i = i + 1) begin
         mr_nxt[i] = mr_r[i];
      end

      // counter and prescaler
      if (tcr_r[`TCMP_TCR_RST]) begin
         tc_nxt = `TCMP_RST_ZERO16;
         pc_nxt = `TCMP_RST_ZERO16;
      end else if (run & cnt_evt) begin
         if (wrap) begin
            pc_nxt = `TCMP_RST_ZERO16;
            if (|hit_rst) begin
               tc_nxt = `TCMP_RST_ZERO16;
            end else begin
               tc_nxt = tc_r + `TCMP_PC_STEP;
            end
         end else begin
            pc_nxt = pc_r + `TCMP_PC_STEP;
         end
      end
      if (|hit_stop) begin
         tcr_nxt[`TCMP_TCR_EN] = 1'b0;
      end

      // external match outputs
      for (i = 0; i < `TCMP_NMATCH; i = i + 1) begin
         act = emr_r[`TCMP_EMR_CTL_LSB + 2*i +: 2];
         if (pwm_r[i]) begin
            if (hit[i]) begin
               emr_nxt[i] = 1'b1;
            end else if (|hit_rst) begin
               emr_nxt[i] = 1'b0;
            end
         end else if (hit[i]) begin
            case (act)
               `TCMP_EMA_LOW:    emr_nxt[i] = 1'b0;
               `TCMP_EMA_HIGH:   emr_nxt[i] = 1'b1;
               `TCMP_EMA_TOGGLE: emr_nxt[i] = ~emr_r[i];
               default:          emr_nxt[i] = emr_r[i];
            endcase
         end
      end

      if (cap_evt) begin
         cr_nxt = tc_r;
      end

      // bus writes; a flag set in the clearing cycle survives
      wr = cyc_i & stb_i & we_i & ~ack_o;
      if (wr & sel_i[0] & (adr_i == `TCMP_OFS_FLAGS)) begin
         flags_nxt = flags_r & ~dat_i[4:0];
      end
      flags_nxt = flags_nxt | flag_set;
      if (wr) begin
         if (adr_i == `TCMP_OFS_TCR) begin
            tmp16   = wb_merge16({14'h0000, tcr_r}, dat_i[15:0], sel_i[1:0]);
            tcr_nxt = tmp16[1:0];
         end else if (adr_i == `TCMP_OFS_TC) begin
            tc_nxt = wb_merge16(tc_r, dat_i[15:0], sel_i[1:0]);
         end else if (adr_i == `TCMP_OFS_PR) begin
            pr_nxt = wb_merge16(pr_r, dat_i[15:0], sel_i[1:0]);
         end else if (adr_i == `TCMP_OFS_PC) begin
            pc_nxt = wb_merge16(pc_r, dat_i[15:0], sel_i[1:0]);
         end else if (adr_i == `TCMP_OFS_MCR) begin
            tmp16   = wb_merge16({4'h0, mcr_r}, dat_i[15:0], sel_i[1:0]);
            mcr_nxt = tmp16[11:0];
         end else if (adr_i == `TCMP_OFS_MR0) begin
            mr_nxt[0] = wb_merge16(mr_r[0], dat_i[15:0], sel_i[1:0]);
         end else if (adr_i == `TCMP_OFS_MR1) begin
            mr_nxt[1] = wb_merge16(mr_r[1], dat_i[15:0], sel_i[1:0]);
         end else if (adr_i == `TCMP_OFS_MR2) begin
            mr_nxt[2] = wb_merge16(mr_r[2], dat_i[15:0], sel_i[1:0]);
         end else if (adr_i == `TCMP_OFS_MR3) begin
            mr_nxt[3] = wb_merge16(mr_r[3], dat_i[15:0], sel_i[1:0]);
         end else if (adr_i == `TCMP_OFS_CCR) begin
            tmp16   = wb_merge16({13'h0000, ccr_r}, dat_i[15:0], sel_i[1:0]);
            ccr_nxt = tmp16[2:0];
         end else if (adr_i == `TCMP_OFS_EMR) begin
            tmp16   = wb_merge16({4'h0, emr_r}, dat_i[15:0], sel_i[1:0]);
            emr_nxt = tmp16[11:0];
         end else if (adr_i == `TCMP_OFS_CTCR) begin
            tmp16    = wb_merge16({12'h000, ctcr_r}, dat_i[15:0], sel_i[1:0]);
            ctcr_nxt = tmp16[3:0];
         end else if (adr_i == `TCMP_OFS_PWM) begin
            tmp16   = wb_merge16({12'h000, pwm_r}, dat_i[15:0], sel_i[1:0]);
            pwm_nxt = tmp16[3:0];
         end else if (adr_i == `TCMP_OFS_MASK) begin
            tmp16    = wb_merge16({11'h000, mask_r}, dat_i[15:0], sel_i[1:0]);
            mask_nxt = tmp16[4:0];
         end
      end

      // read mux; unmapped offsets read zero
      if (adr_i == `TCMP_OFS_FLAGS) begin
         rd_nxt = {27'h000_0000, flags_r};
      end else if (adr_i == `TCMP_OFS_TCR) begin
         rd_nxt = {30'h0000_0000, tcr_r};
      end else if (adr_i == `TCMP_OFS_TC) begin
         rd_nxt = {16'h0000, tc_r};
      end else if (adr_i == `TCMP_OFS_PR) begin
         rd_nxt = {16'h0000, pr_r};
      end else if (adr_i == `TCMP_OFS_PC) begin
         rd_nxt = {16'h0000, pc_r};
      end else if (adr_i == `TCMP_OFS_MCR) begin
         rd_nxt = {20'h0_0000, mcr_r};
      end else if (adr_i == `TCMP_OFS_MR0) begin
         rd_nxt = {16'h0000, mr_r[0]};
      end else if (adr_i == `TCMP_OFS_MR1) begin
         rd_nxt = {16'h0000, mr_r[1]};
      end else if (adr_i == `TCMP_OFS_MR2) begin
         rd_nxt = {16'h0000, mr_r[2]};
      end else if (adr_i == `TCMP_OFS_MR3) begin
         rd_nxt = {16'h0000, mr_r[3]};
      end else if (adr_i == `TCMP_OFS_CCR) begin
         rd_nxt = {29'h0000_0000, ccr_r};
      end else if (adr_i == `TCMP_OFS_CR) begin
         rd_nxt = {16'h0000, cr_r};
      end else if (adr_i == `TCMP_OFS_EMR) begin
         rd_nxt = {20'h0_0000, emr_r};
      end else if (adr_i == `TCMP_OFS_CTCR) begin
         rd_nxt = {28'h000_0000, ctcr_r};
      end else if (adr_i == `TCMP_OFS_PWM) begin
         rd_nxt = {28'h000_0000, pwm_r};
      end else if (adr_i == `TCMP_OFS_MASK) begin
         rd_nxt = {27'h000_0000, mask_r};
      end else begin
         rd_nxt = 32'h0000_0000;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         flags_r         <= 5'h00;
         tcr_r           <= 2'h0;
         tc_r            <= `TCMP_RST_ZERO16;
         pr_r            <= `TCMP_RST_ZERO16;
         pc_r            <= `TCMP_RST_ZERO16;
         mcr_r           <= 12'h000;
         ccr_r           <= 3'h0;
         cr_r            <= `TCMP_RST_ZERO16;
         emr_r           <= 12'h000;
         ctcr_r          <= 4'h0;
         pwm_r           <= 4'h0;
         mask_r          <= `TCMP_RST_MASK;
         ack_o           <= 1'b0;
         dat_o           <= 32'h0000_0000;
         match_outputs_o <= 3'h0;
         irq_o           <= 1'b0;
         for (i = 0; i < `TCMP_NMATCH; i = i + 1) begin
            mr_r[i] <= `TCMP_RST_ZERO16;
         end
      end else begin
         flags_r         <= flags_nxt;
         tcr_r           <= tcr_nxt;
         tc_r            <= tc_nxt;
         pr_r            <= pr_nxt;
         pc_r            <= pc_nxt;
         mcr_r           <= mcr_nxt;
         ccr_r           <= ccr_nxt;
         cr_r            <= cr_nxt;
         emr_r           <= emr_nxt;
         ctcr_r          <= ctcr_nxt;
         pwm_r           <= pwm_nxt;
         mask_r          <= mask_nxt;
         // single-cycle ack; the master must drop stb before a new request
         ack_o           <= cyc_i & stb_i & ~ack_o;
         dat_o           <= rd_nxt;
         // second instance drives only two pins
         match_outputs_o <= emr_nxt[2:0] & pin_mask;
         irq_o           <= |(flags_nxt & mask_nxt);
         for (i = 0; i < `TCMP_NMATCH; i = i + 1) begin
            mr_r[i] <= mr_nxt[i];
         end
      end
   end
endmodule

// file: tb/tcmp_pin_model.sv
`timescale 1ns/100ps
module tcmp_pin_model (
   // clock
   input  wire       clk_i,
   // match pins from the timer
   input  wire [2:0] pins_i,
   // capture pin to the timer
   output logic      cap_o
);
   logic [2:0] prev_r = 3'b000;
   int         now = 0;
   int         rise_t [3];
   int         period [3];
   int         high   [3];
   initial cap_o = 1'b0;
   // rise-to-rise period and high time of each pin, in clocks
   always @(posedge clk_i) begin
      now <= now + 1;
      prev_r <= pins_i;
      for (int i = 0; i < 3; i++) begin
         if (pins_i[i] && !prev_r[i]) begin
            period[i] <= now - rise_t[i];
            rise_t[i] <= now;
         end
         if (!pins_i[i] && prev_r[i])
            high[i] <= now - rise_t[i];
      end
   end
   // held well past the synchroniser so no edge is lost
   task edge_to(input logic v);
      @(posedge clk_i);
      cap_o <= v;
      repeat (6) @(posedge clk_i);
   endtask
endmodule

// file: tb/tcmp_timer_assertions.sv
`timescale 1ns/100ps
`include "tcmp_consts.vh"
module tcmp_timer_assertions #(
   parameter MATCH_PINS = 3
) (
   // clock and reset
   input wire        clk_i,
   input wire        rst_i,
   // bus
   input wire        cyc_i,
   input wire        stb_i,
   input wire        we_i,
   input wire [7:0]  adr_i,
   input wire [3:0]  sel_i,
   input wire [31:0] dat_i,
   input wire [31:0] dat_o,
   input wire        ack_o,
   // pins and interrupt
   input wire        capture_input_i,
   input wire [2:0]  match_outputs_o,
   input wire        irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_take;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence s_hole_rd;
      s_take ##0 (!we_i && adr_i == 8'h40);
   endsequence
   sequence s_mask_off;
      s_take ##0 (we_i && sel_i[0] && adr_i == `TCMP_OFS_MASK && dat_i[4:0] == 5'h00);
   endsequence
   AST_ACK_TAKE: assert property (s_take |=> ack_o)
      else $error("ack missing after request");
   AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   AST_ACK_IDLE: assert property (!(cyc_i && stb_i) |=> !ack_o)
      else $error("ack without request");
   AST_HOLE_READ: assert property (s_hole_rd |=> (ack_o && dat_o == 32'h0000_0000))
      else $error("unmapped read not zero");
   AST_IRQ_FALL: assert property ($fell(irq_o) |-> (ack_o || $past(ack_o)))
      else $error("irq dropped without a write");
   AST_MASK_OFF: assert property (s_mask_off |=> ##2 !irq_o)
      else $error("irq high with all sources masked");
   AST_RST_IDLE: assert property ($fell(rst_i) |-> (!irq_o && match_outputs_o == 3'b000))
      else $error("outputs not idle after reset");
   AST_PIN2_ZERO: assert property ((MATCH_PINS == 2) |-> !match_outputs_o[2])
      else $error("unpinned match output driven");
endmodule

// file: tb/tcmp_tb.sv
`timescale 1ns/100ps
`include "tcmp_consts.vh"
module tb;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_a = 1'b0;
   logic        cyc_b = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i  = 1'b0;
   logic [7:0]  adr_i = 8'h00;
   logic [3:0]  sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0000_0000;
   logic [31:0] rdat;
   logic [3:0]  lanes = 4'h3;
   wire  [31:0] dat_a;
   wire  [31:0] dat_b;
   wire         ack_a;
   wire         ack_b;
   wire         irq_a;
   wire         irq_b;
   wire         cap_a;
   wire         cap_b;
   wire  [2:0]  mo_a;
   wire  [2:0]  mo_b;
   int          miscompares = 0;
   int          checks_done = 0;
   int          cycles = 0;
   initial forever #2.5 clk_i = ~clk_i;
   tcmp_timer #(.MATCH_PINS(3)) tcmp_timer_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_a),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_a),
      .ack_o(ack_a), .capture_input_i(cap_a), .match_outputs_o(mo_a), .irq_o(irq_a));
   tcmp_timer #(.MATCH_PINS(2)) tcmp_timer_b_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_b),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_b),
      .ack_o(ack_b), .capture_input_i(cap_b), .match_outputs_o(mo_b), .irq_o(irq_b));
   tcmp_pin_model tcmp_pin_model_inst (.clk_i(clk_i), .pins_i(mo_a), .cap_o(cap_a));
   tcmp_pin_model tcmp_pin_model_b_inst (.clk_i(clk_i), .pins_i(mo_b), .cap_o(cap_b));
   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // b selects the instance; request held until ack is sampled
   task bus(input int b, input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc_a <= (b == 0);
      cyc_b <= (b == 1);
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= lanes;
      do begin
         @(posedge clk_i);
         n++;
      end while (((b == 0) ? ack_a : ack_b) !== 1'b1 && n < 40);
      rdat = (b == 0) ? dat_a : dat_b;
      chk("bus ack", n < 40, 32'h0000_0001);
      cyc_a <= 1'b0;
      cyc_b <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task wr(input int b, input logic [7:0] a, input logic [31:0] d);
      bus(b, 1'b1, a, d);
   endtask
   task rd(input int b, input logic [7:0] a);
      bus(b, 1'b0, a, 32'h0000_0000);
   endtask
   task t_reset;
      for (int b = 0; b < 2; b++)
         for (int a = 0; a <= 8'h78; a += 4) begin
            rd(b, a[7:0]);
            chk("reset read", rdat, (a == 8'h78) ? 32'h0000_001F : 32'h0000_0000);
         end
   endtask
   // mr3 unpinned sets the period; pin0 toggles, pin2 is pwm
   task t_match_pwm(input int b);
      wr(b, `TCMP_OFS_PR, 32'h0000_0001);
      wr(b, `TCMP_OFS_MR3, 32'h0000_0003);
      wr(b, `TCMP_OFS_MR0, 32'h0000_0001);
      wr(b, `TCMP_OFS_MR2, 32'h0000_0001);
      wr(b, `TCMP_OFS_MCR, 32'h0000_0400);
      wr(b, `TCMP_OFS_EMR, 32'h0000_0030);
      wr(b, `TCMP_OFS_PWM, 32'h0000_0004);
      wr(b, `TCMP_OFS_TCR, 32'h0000_0001);
      repeat (80) @(posedge clk_i);
      chk("pin0 period", b ? tcmp_pin_model_b_inst.period[0] : tcmp_pin_model_inst.period[0],
          32'h0000_0010);
      chk("pin2 period", b ? tcmp_pin_model_b_inst.period[2] : tcmp_pin_model_inst.period[2],
          b ? 32'h0000_0000 : 32'h0000_0008);
      chk("pin2 high", b ? tcmp_pin_model_b_inst.high[2] : tcmp_pin_model_inst.high[2],
          b ? 32'h0000_0000 : 32'h0000_0004);
      wr(b, `TCMP_OFS_TCR, 32'h0000_0002);
   endtask
   task t_emr;
      logic [31:0] external_match_control [3];
      external_match_control = '{32'h0000_0080, 32'h0000_0002, 32'h0000_0042};
      wr(0, `TCMP_OFS_MR1, 32'h0000_0002);
      wr(0, `TCMP_OFS_PWM, 32'h0000_0000);
      wr(0, `TCMP_OFS_TCR, 32'h0000_0001);
      for (int i = 0; i < 3; i++) begin
         wr(0, `TCMP_OFS_EMR, external_match_control[i]);
         repeat (20) @(posedge clk_i);
         chk("pin1 level", mo_a[1], (i < 2) ? 32'h0000_0001 : 32'h0000_0000);
      end
      wr(0, `TCMP_OFS_TCR, 32'h0000_0002);
   endtask
   task t_capture;
      wr(0, `TCMP_OFS_TCR, 32'h0000_0000);
      wr(0, `TCMP_OFS_TC, 32'h0000_1234);
      wr(0, `TCMP_OFS_CCR, 32'h0000_0005);
      tcmp_pin_model_inst.edge_to(1'b1);
      rd(0, `TCMP_OFS_CR);
      chk("capture", rdat, 32'h0000_1234);
      rd(0, `TCMP_OFS_FLAGS);
      chk("flags", rdat, 32'h0000_0010);
      chk("irq", irq_a, 32'h0000_0001);
      wr(0, `TCMP_OFS_MASK, 32'h0000_0000);
      chk("irq masked", irq_a, 32'h0000_0000);
      wr(0, `TCMP_OFS_MASK, 32'h0000_001F);
      chk("irq unmasked", irq_a, 32'h0000_0001);
      wr(0, `TCMP_OFS_FLAGS, 32'h0000_0010);
      chk("irq cleared", irq_a, 32'h0000_0000);
      wr(0, `TCMP_OFS_CCR, 32'h0000_0006);
      wr(0, `TCMP_OFS_TC, 32'h0000_5678);
      tcmp_pin_model_inst.edge_to(1'b0);
      wr(0, `TCMP_OFS_TC, 32'h0000_9ABC);
      tcmp_pin_model_inst.edge_to(1'b1);
      rd(0, `TCMP_OFS_CR);
      chk("capture fall only", rdat, 32'h0000_5678);
   endtask
   task t_counter;
      logic [31:0] mode [3];
      int          np [3];
      logic [31:0] tc_exp [3];
      mode = '{32'h0000_0001, 32'h0000_0003, 32'h0000_0007};
      np = '{5, 3, 2};
      tc_exp = '{32'h0000_0005, 32'h0000_000B, 32'h0000_000B};
      wr(0, `TCMP_OFS_MCR, 32'h0000_0000);
      wr(0, `TCMP_OFS_PR, 32'h0000_0000);
      wr(0, `TCMP_OFS_CCR, 32'h0000_0000);
      // select edge counting before enabling, or timer mode adds clock ticks
      wr(0, `TCMP_OFS_CTCR, 32'h0000_0001);
      wr(0, `TCMP_OFS_FLAGS, 32'h0000_001F);
      wr(0, `TCMP_OFS_TC, 32'h0000_0000);
      wr(0, `TCMP_OFS_TCR, 32'h0000_0001);
      for (int i = 0; i < 3; i++) begin
         wr(0, `TCMP_OFS_CTCR, mode[i]);
         repeat (np[i]) begin
            tcmp_pin_model_inst.edge_to(1'b0);
            tcmp_pin_model_inst.edge_to(1'b1);
         end
         rd(0, `TCMP_OFS_TC);
         chk("edge count", rdat, tc_exp[i]);
      end
      wr(0, `TCMP_OFS_TCR, 32'h0000_0002);
   endtask
   task t_stop;
      logic [31:0] held;
      wr(0, `TCMP_OFS_CTCR, 32'h0000_0000);
      wr(0, `TCMP_OFS_MCR, 32'h0000_0228);
      wr(0, `TCMP_OFS_MR1, 32'h0000_0006);
      wr(0, `TCMP_OFS_MR3, 32'h0000_0002);
      wr(0, `TCMP_OFS_TCR, 32'h0000_0001);
      repeat (40) @(posedge clk_i);
      rd(0, `TCMP_OFS_TCR);
      chk("stopped", rdat, 32'h0000_0000);
      rd(0, `TCMP_OFS_FLAGS);
      chk("match flags", rdat, 32'h0000_000A);
      rd(0, `TCMP_OFS_TC);
      held = rdat;
      chk("stop value", held, 32'h0000_0007);
      rd(0, `TCMP_OFS_TC);
      chk("count held", rdat, held);
   endtask
   // second instance: capture without interrupt, then a low-lane-only write
   task t_capture_b;
      wr(1, `TCMP_OFS_TCR, 32'h0000_0000);
      wr(1, `TCMP_OFS_TC, 32'h0000_0042);
      wr(1, `TCMP_OFS_CCR, 32'h0000_0003);
      tcmp_pin_model_b_inst.edge_to(1'b1);
      rd(1, `TCMP_OFS_CR);
      chk("capture b", rdat, 32'h0000_0042);
      rd(1, `TCMP_OFS_FLAGS);
      chk("capture b no flag", rdat, 32'h0000_0000);
      chk("irq b idle", irq_b, 32'h0000_0000);
      lanes = 4'h1;
      wr(1, `TCMP_OFS_MR0, 32'h0000_ABCD);
      lanes = 4'h3;
      rd(1, `TCMP_OFS_MR0);
      chk("byte lane", rdat, 32'h0000_00CD);
   endtask
   // whole run is under a thousand cycles
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         test_done;
      end
   end
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset;
      t_match_pwm(0);
      t_emr;
      t_match_pwm(1);
      t_capture;
      t_capture_b;
      t_counter;
      t_stop;
      test_done;
   end
endmodule
bind tcmp_timer tcmp_timer_assertions #(.MATCH_PINS(MATCH_PINS)) tcmp_timer_assertions_inst (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
   .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
   .capture_input_i(capture_input_i), .match_outputs_o(match_outputs_o), .irq_o(irq_o));
